/* File: mdsup_fault_if.sv */
// Interface carrying fault indications and latched flags between modules
`timescale 1ns/1ps
interface mdsup_fault_if;
  import mdsup_pkg::*;
  // Raw indications
  logic temp_warn;
  logic temp_shut;
  logic [OVC_W-1:0] ovc_x;
  logic [OVC_W-1:0] ovc_y;
  logic full_x;
  logic full_y;
  logic cp_low;
  // Control
  logic read_clear;
  logic upd_en;
  logic hclr;
  // Latched flags
  logic tw_flag;
  logic tsd_flag;
  logic [OVC_W-1:0] ovcx_flags;
  logic [OVC_W-1:0] ovcy_flags;
  logic open_coil_x_flag_flag;
  logic open_coil_y_flag_flag;
  logic cp_flag;
  modport src (output temp_warn, temp_shut, ovc_x, ovc_y, full_x, full_y,
    cp_low, read_clear, upd_en, hclr,
    input tw_flag, tsd_flag, ovcx_flags, ovcy_flags, open_coil_x_flag_flag, open_coil_y_flag_flag,
    cp_flag);
  modport lat (input temp_warn, temp_shut, ovc_x, ovc_y, full_x, full_y,
    cp_low, read_clear, upd_en, hclr,
    output tw_flag, tsd_flag, ovcx_flags, ovcy_flags, open_coil_x_flag_flag, open_coil_y_flag_flag,
    cp_flag);
endinterface : mdsup_fault_if

/* File: mdsup_fault_latch.sv */
// Latched fault flags with read clear and open coil timers
`timescale 1ns/1ps
module mdsup_fault_latch
  import mdsup_pkg::*;
#(
  parameter int unsigned OPEN_CYCLES = OPEN_CYC
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Fault bundle
  mdsup_fault_if.lat f
);
  import mdsup_pkg::*;

  logic [27:0] ox_q; // Full duty timer, coil X
  logic [27:0] oy_q; // Full duty timer, coil Y
  logic ox_hit; // Coil X past limit
  logic oy_hit; // Coil Y past limit
  logic tick; // Flag update allowed
  logic clr; // Clear latched flags

  assign ox_hit = (ox_q >= 28'(OPEN_CYCLES));
  assign oy_hit = (oy_q >= 28'(OPEN_CYCLES));
  assign tick = clk_en && f.upd_en;
  assign clr = f.read_clear;

  // Full duty timers, stop at limit
  always_ff @(posedge clk)
  begin
    if (srst || f.hclr)
    begin
      ox_q <= 28'h0000000;
      oy_q <= 28'h0000000;
    end
    else if (clk_en)
    begin
      ox_q <= !f.full_x ? 28'h0000000 : (ox_hit ? ox_q : ox_q + 28'h0000001);
      oy_q <= !f.full_y ? 28'h0000000 : (oy_hit ? oy_q : oy_q + 28'h0000001);
    end
  end

  // Flags: set wins over read clear; updates only while chip select high
  always_ff @(posedge clk)
  begin
    if (srst || f.hclr)
    begin
      f.tw_flag <= 1'b0;
      f.tsd_flag <= 1'b0;
      f.ovcx_flags <= 4'h0;
      f.ovcy_flags <= 4'h0;
      f.open_coil_x_flag_flag <= 1'b0;
      f.open_coil_y_flag_flag <= 1'b0;
    end
    else if (tick)
    begin
      f.tw_flag <= f.temp_warn || (f.tw_flag && !clr); // see R4 see R23
      // Shutdown clears only below warning level and after a read
      f.tsd_flag <= f.temp_shut || (f.tsd_flag && !(clr && !f.temp_warn)); // see R5
      f.ovcx_flags <= f.ovc_x | (clr ? 4'h0 : f.ovcx_flags); // see R6
      f.ovcy_flags <= f.ovc_y | (clr ? 4'h0 : f.ovcy_flags); // see R6
      f.open_coil_x_flag_flag <= ox_hit || (f.open_coil_x_flag_flag && !clr); // see R7 see R8
      f.open_coil_y_flag_flag <= oy_hit || (f.open_coil_y_flag_flag && !clr); // see R7 see R8
    end
  end

  // Charge pump flag follows the level, set from reset
  always_ff @(posedge clk)
  begin
    if (srst)
      f.cp_flag <= 1'b1; // see R9
    else if (tick)
      f.cp_flag <= f.cp_low; // see R9
  end

  // Open flag rises once timer passes limit while flags may update
  open_flag_a: assert property (@(posedge clk) disable iff (srst || f.hclr)
    (ox_hit && tick) |=> f.open_coil_x_flag_flag) // see R7
    else $error("open coil flag not set");
  tsd_hold_a: assert property (@(posedge clk) disable iff (srst || f.hclr)
    (f.tsd_flag && f.temp_warn && clk_en) |=> f.tsd_flag) // see R5
    else $error("shutdown flag cleared while warm");
endmodule : mdsup_fault_latch

/* File: mdsup_host_model.sv */
// Host microcontroller model: services the watchdog and reads status
`timescale 1ns/1ps
module mdsup_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Commands from the bench
  input wire logic wd_arm,
  input wire logic rd_go,
  input wire logic hold_cs,
  input wire logic [9:0] svc_gap,
  // Control lines toward the device
  output logic watchdog_enable_bit,
  output logic watchdog_enable_wr,
  output logic spi_cs_n,
  output logic status_read
);
  // Cycles since the last rewrite
  logic [9:0] gap_q = 10'h000;
  // Read sequencer, counts down from 3
  logic [1:0] rd_q = 2'h0;
  // Idle levels before the first falling edge
  initial
  begin
    watchdog_enable_bit = 1'b0;
    watchdog_enable_wr = 1'b0;
    spi_cs_n = 1'b1;
    status_read = 1'b0;
  end
  // Only this side starts a transfer; all changes on the falling edge
  always @(negedge clk)
  begin
    watchdog_enable_wr <= 1'b0;
    status_read <= 1'b0;
    gap_q <= gap_q + 10'h001;
    rd_q <= (rd_q != 2'h0) ? rd_q - 2'h1 : 2'h0;
    // Select low during a read or while the bench holds it
    spi_cs_n <= !(hold_cs || rd_q[1]);
    if (srst)
    begin
      watchdog_enable_bit <= 1'b0;
      gap_q <= 10'h000;
    end
    else if (wd_arm || (watchdog_enable_bit && svc_gap != 10'h000 &&
      gap_q >= svc_gap - 10'h001))
    begin
      // Write or rewrite the enable bit
      watchdog_enable_wr <= 1'b1;
      watchdog_enable_bit <= 1'b1;
      gap_q <= 10'h000;
    end
    // Read strobe lands on the same edge that select goes high again
    if (rd_q == 2'h1)
      status_read <= 1'b1;
    if (rd_go)
      rd_q <= 2'h3;
  end
endmodule : mdsup_host_model

/* File: mdsup_pkg.sv */
// Package with timing, width and encoding constants of the motor driver supervisor
package mdsup_pkg;
  // System clock period in picoseconds (125 MHz)
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Watchdog interval step, in milliseconds
  localparam int unsigned WD_STEP_MS = 32;
  // Cycles in one millisecond (1 ms is 1e9 ps); kept apart to stay in 32 bits
  localparam int unsigned MS_CYC = 1000000000 / CLK_PERIOD_PS;
  // Cycles in one watchdog step
  localparam int unsigned WD_STEP_CYC = WD_STEP_MS * MS_CYC;
  // Open coil full duty time, in milliseconds
  localparam int unsigned OPEN_TIME_MS = 200;
  // Open coil cycles (longest time, rounded down)
  localparam int unsigned OPEN_CYC = OPEN_TIME_MS * MS_CYC;
  // Early window limit, in milliseconds (plain default)
  localparam int unsigned WD_EARLY_MS = 8;
  // Early window cycles (least time, rounded up)
  localparam int unsigned WD_EARLY_CYC = WD_EARLY_MS * MS_CYC;
  // Power up reset hold, in microseconds (plain default)
  localparam int unsigned POR_HOLD_US = 100;
  // Power up reset hold cycles
  localparam int unsigned POR_HOLD_CYC = (POR_HOLD_US * 1000000) / CLK_PERIOD_PS;
  // Watchdog reset pulse length in cycles
  localparam int unsigned WD_PULSE_CYC = 1000;
  // Hard clear least hold, in nanoseconds (plain default)
  localparam int unsigned CLR_MIN_NS = 100;
  // Hard clear cycles (least time, rounded up)
  localparam int unsigned CLR_MIN_CYC = (CLR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Widths
  localparam int unsigned CUR_W = 5;
  localparam int unsigned WDT_W = 4;
  localparam int unsigned LA_W = 10;
  localparam int unsigned OVC_W = 4;
  // Gain bit codes: divide by two or by four
  localparam logic LA_GAIN_DIV2 = 1'b0;
  localparam logic LA_GAIN_DIV4 = 1'b1;
  // Reset values
  localparam logic [CUR_W-1:0] CUR_RST = 5'h00;
  localparam logic [LA_W-1:0] LA_RST = 10'h000;
  // Reset output sequencer states, one-hot
  typedef enum logic [2:0]
  {
    MDSUP_ST_POR = 3'h1,
    MDSUP_ST_RUN = 3'h2,
    MDSUP_ST_WDR = 3'h4
  } mdsup_rst_e;
endpackage : mdsup_pkg

/* File: mdsup_top.sv */
// Top of the motor driver supervisor: outputs, watchdog, reset and sleep
// Operation
// R1: New peak setting applies next PWM period.
// R2: Transparent follows voltage, else hold crossing sample.
// R3: Gain bit divides sample by two or four.
// R4: Set warning flag above warning threshold.
// R5: Shutdown flag, drivers off, clear when cool+read.
// R6: Overcurrent latches own flag, drivers off until cleared.
// R7: Full duty too long sets open flag, disables.
// R8: Current not reached: flag, error, current kept.
// R9: Charge pump flag high while pump low.
// R10: Error low when any fault flag set.
// R11: Hold reset output low after power up.
// R12: Watchdog rewrite clears timer before timeout.
// R13: Early or missing rewrite resets microcontroller.
// R14: Boot kind flag tells watchdog from cold.
// R15: Interval is 32 ms times value plus one.
// R16: Hard clear held high resets registers, not sleep.
// R17: Hard clear resets watchdog, no reset output.
// R18: Sleep: drivers off, registers kept, clocks stopped.
// R19: Host keeps step inputs still during sleep.
// R20: Watchdog counter freezes in sleep, then resumes.
// R21: Host clears sleep, waits pump startup.
// R22: Device only ever acts as SPI slave.
// R23: Status read clears flags; update only chip select high.
// R24: Watchdog reset pulse lasts parameter cycles.
`timescale 1ns/1ps
module mdsup_top
  import mdsup_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = WD_STEP_CYC,
  parameter int unsigned EARLY_CYCLES = WD_EARLY_CYC,
  parameter int unsigned OPEN_CYCLES = OPEN_CYC,
  parameter int unsigned POR_CYCLES = POR_HOLD_CYC,
  parameter int unsigned PULSE_CYCLES = WD_PULSE_CYC
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Control bits from the SPI slave
  input wire logic [mdsup_pkg::CUR_W-1:0] peak_amplitude_setting,
  input wire logic load_angle_transparent,
  input wire logic load_angle_gain,
  input wire logic watchdog_enable_bit,
  input wire logic watchdog_enable_wr,
  input wire logic [mdsup_pkg::WDT_W-1:0] watchdog_interval_sel,
  input wire logic sleep_bit,
  input wire logic motor_enable,
  input wire logic status_read,
  input wire logic spi_cs_n,
  // Analog indications
  input wire logic pwm_period_start,
  input wire logic [mdsup_pkg::LA_W-1:0] coil_voltage,
  input wire logic zero_cross_end,
  input wire logic temp_warn_in,
  input wire logic temp_shut_in,
  input wire logic [mdsup_pkg::OVC_W-1:0] ovc_x_in,
  input wire logic [mdsup_pkg::OVC_W-1:0] ovc_y_in,
  input wire logic full_duty_x,
  input wire logic full_duty_y,
  input wire logic cp_low_in,
  input wire logic current_unreachable,
  // Hard clear pin
  input wire logic hard_clear_in,
  // Current and load angle
  output logic [mdsup_pkg::CUR_W-1:0] coil_amplitude,
  output logic [mdsup_pkg::LA_W-1:0] load_angle_output,
  // Driver control
  output logic drivers_on_x,
  output logic drivers_on_y,
  // Status flags
  output logic thermal_warning_flag,
  output logic thermal_shutdown_flag,
  output logic [mdsup_pkg::OVC_W-1:0] overcurrent_x_flags,
  output logic [mdsup_pkg::OVC_W-1:0] overcurrent_y_flags,
  output logic open_coil_x_flag,
  output logic open_coil_y_flag,
  output logic charge_pump_fault_flag,
  output logic boot_kind_flag,
  // Error and reset pins
  output logic error_out_n,
  output logic reset_out_o,
  output logic reset_out_oe,
  // Internal clock gate
  output logic core_clk_run
);
  import mdsup_pkg::*;

  // Scale sample by gain code
  function automatic logic [LA_W-1:0] la_scale(input logic [LA_W-1:0] v,
                                               input logic g);
    la_scale = (g == LA_GAIN_DIV4) ? (v >> 2) : (v >> 1);
  endfunction : la_scale

  mdsup_fault_if fb ();

  mdsup_rst_e st_q; // Reset output sequencer
  mdsup_rst_e st_d; // Next sequencer state
  logic [31:0] rcnt_q; // Reset hold counter
  logic [31:0] wcnt_q; // Watchdog timer
  logic [31:0] ccnt_q; // Hard clear hold counter
  logic wd_act_q; // Watchdog armed
  logic boot_q; // Boot kind flag
  logic [CUR_W-1:0] amp_q; // Applied amplitude
  logic [LA_W-1:0] la_q; // Load angle output
  logic hclr_q; // Hard clear accepted
  logic run; // Clock runs
  logic hclr_ok; // Hard clear active, not asleep
  logic [31:0] limit; // Timeout in cycles
  logic early_hit; // Rewrite too early
  logic late_hit; // Timeout reached
  logic wd_fire; // Watchdog reset trigger
  logic rst_done; // Reset hold finished
  logic any_flag; // Any fault latched
  logic ovc_any; // Any overcurrent latched

  // Clocks stop in sleep except during SPI activity
  assign run = clk_en && (!sleep_bit || !spi_cs_n); // see R18
  assign core_clk_run = run;
  assign hclr_ok = hard_clear_in && !sleep_bit; // see R16
  // Timeout is step times value plus one
  assign limit = 32'(STEP_CYCLES) * (32'(watchdog_interval_sel) + 32'h00000001); // see R15
  assign early_hit = watchdog_enable_wr && (wcnt_q < 32'(EARLY_CYCLES));
  assign late_hit = (wcnt_q >= limit - 32'h00000001);
  assign wd_fire = wd_act_q && !sleep_bit && (early_hit || late_hit); // see R13
  assign rst_done = (st_q == MDSUP_ST_POR) ? (rcnt_q >= 32'(POR_CYCLES) - 32'h00000001)
                  : (rcnt_q >= 32'(PULSE_CYCLES) - 32'h00000001);

  // Fault bundle wiring
  assign fb.temp_warn = temp_warn_in;
  assign fb.temp_shut = temp_shut_in;
  assign fb.ovc_x = ovc_x_in;
  assign fb.ovc_y = ovc_y_in;
  assign fb.full_x = full_duty_x || current_unreachable;
  assign fb.full_y = full_duty_y || current_unreachable;
  assign fb.cp_low = cp_low_in;
  assign fb.read_clear = status_read; // see R23
  assign fb.upd_en = spi_cs_n; // see R22 see R23
  assign fb.hclr = hclr_q;

  mdsup_fault_latch #(
    .OPEN_CYCLES(OPEN_CYCLES)
  ) u_fault (
    .clk(clk),
    .srst(srst),
    .clk_en(run),
    .f(fb)
  );

  assign thermal_warning_flag = fb.tw_flag;
  assign thermal_shutdown_flag = fb.tsd_flag;
  assign overcurrent_x_flags = fb.ovcx_flags;
  assign overcurrent_y_flags = fb.ovcy_flags;
  assign open_coil_x_flag = fb.open_coil_x_flag_flag;
  assign open_coil_y_flag = fb.open_coil_y_flag_flag;
  assign charge_pump_fault_flag = fb.cp_flag;
  assign boot_kind_flag = boot_q;
  assign ovc_any = |{fb.ovcx_flags, fb.ovcy_flags};
  assign any_flag = fb.tw_flag || fb.tsd_flag || ovc_any || fb.open_coil_x_flag_flag
                 || fb.open_coil_y_flag_flag || fb.cp_flag;
  assign error_out_n = !any_flag; // see R10

  // Drivers off on shutdown, overcurrent, sleep; open coil only when not
  // a current shortfall, where the current is kept flowing
  assign drivers_on_x = motor_enable && !sleep_bit && !fb.tsd_flag && !ovc_any
    && !(fb.open_coil_x_flag_flag && !current_unreachable); // see R5 see R6 see R7 see R8 see R18
  assign drivers_on_y = motor_enable && !sleep_bit && !fb.tsd_flag && !ovc_any
    && !(fb.open_coil_y_flag_flag && !current_unreachable); // see R5 see R6 see R7 see R8 see R18

  // Open drain reset pin: drive low while holding reset
  assign reset_out_o = 1'b0;
  assign reset_out_oe = (st_q != MDSUP_ST_RUN); // see R11 see R24
  assign coil_amplitude = amp_q;
  assign load_angle_output = la_q;

  // Sequencer next state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      MDSUP_ST_POR: if (rst_done) st_d = MDSUP_ST_RUN; // see R11
      MDSUP_ST_RUN: if (wd_fire) st_d = MDSUP_ST_WDR; // see R13
      MDSUP_ST_WDR: if (rst_done) st_d = MDSUP_ST_RUN; // see R24
      default: st_d = MDSUP_ST_POR;
    endcase
  end

  // Sequencer state and hold counter; hard clear never asserts the pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= MDSUP_ST_POR;
      rcnt_q <= 32'h00000000;
    end
    else if (run)
    begin
      st_q <= (hclr_q && st_q == MDSUP_ST_WDR) ? MDSUP_ST_RUN : st_d; // see R17
      rcnt_q <= (st_d != st_q || st_q == MDSUP_ST_RUN) ? 32'h00000000
              : rcnt_q + 32'h00000001;
    end
  end

  // Hard clear accepted after its least hold time
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ccnt_q <= 32'h00000000;
      hclr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ccnt_q <= !hclr_ok ? 32'h00000000
              : (hclr_q ? ccnt_q : ccnt_q + 32'h00000001);
      hclr_q <= hclr_ok && (ccnt_q >= 32'(CLR_MIN_CYC) - 32'h00000001); // see R16
    end
  end

  // Watchdog timer: rewrite clears, sleep freezes, hard clear resets
  always_ff @(posedge clk)
  begin
    if (srst || hclr_q)
    begin
      wcnt_q <= 32'h00000000; // see R17
      wd_act_q <= 1'b0;
    end
    else if (run && !sleep_bit) // see R20
    begin
      if (wd_fire || st_q != MDSUP_ST_RUN)
      begin
        wcnt_q <= 32'h00000000;
        wd_act_q <= 1'b0;
      end
      else if (watchdog_enable_wr)
      begin
        wcnt_q <= 32'h00000000; // see R12
        wd_act_q <= watchdog_enable_bit;
      end
      else if (wd_act_q)
        wcnt_q <= wcnt_q + 32'h00000001;
    end
  end

  // Boot kind: one after a watchdog reset, zero after cold start
  always_ff @(posedge clk)
  begin
    if (srst)
      boot_q <= 1'b0;
    else if (run && wd_fire)
      boot_q <= 1'b1; // see R14
  end

  // Amplitude taken at PWM period start
  always_ff @(posedge clk)
  begin
    if (srst || hclr_q)
      amp_q <= CUR_RST;
    else if (run && pwm_period_start)
      amp_q <= peak_amplitude_setting; // see R1
  end

  // Load angle: transparent or sample and hold, scaled by gain
  always_ff @(posedge clk)
  begin
    if (srst || hclr_q)
      la_q <= LA_RST;
    else if (run && (load_angle_transparent || zero_cross_end)) // see R2
      la_q <= la_scale(coil_voltage, load_angle_gain); // see R3
  end

  sequence wd_late_s;
    wd_act_q && late_hit && run && !sleep_bit && st_q == MDSUP_ST_RUN;
  endsequence
  sequence pin_low_s;
    reset_out_oe [*2];
  endsequence

  wd_timeout_a: assert property (@(posedge clk) disable iff (srst || hclr_q)
    wd_late_s |=> pin_low_s) // see R13
    else $error("timeout did not reset host");
  err_pin_a: assert property (@(posedge clk) disable iff (srst)
    fb.tsd_flag |-> !error_out_n) // see R10
    else $error("error pin high with fault");
  sleep_frz_a: assert property (@(posedge clk) disable iff (srst || hclr_q)
    (sleep_bit && $past(sleep_bit)) |-> $stable(wcnt_q)) // see R20
    else $error("watchdog moved in sleep");
  la_hold_a: assert property (@(posedge clk) disable iff (srst || hclr_q)
    (run && !load_angle_transparent && !zero_cross_end) |=> $stable(la_q)) // see R2
    else $error("load angle moved while held");
  amp_apply_a: assert property (@(posedge clk) disable iff (srst || hclr_q)
    (run && pwm_period_start) |=> amp_q == $past(peak_amplitude_setting)) // see R1
    else $error("amplitude not applied");
  boot_kind_a: assert property (@(posedge clk) disable iff (srst)
    (run && wd_fire) |=> boot_kind_flag) // see R14
    else $error("boot kind not set");
  drv_off_a: assert property (@(posedge clk) disable iff (srst)
    (ovc_any || sleep_bit) |-> !drivers_on_x && !drivers_on_y) // see R6
    else $error("drivers on during fault");
  por_hold_a: assert property (@(posedge clk)
    $fell(srst) |-> reset_out_oe) // see R11
    else $error("reset pin released early");
endmodule : mdsup_top

/* File: mdsup_top_tb.sv */
// Self-checking bench for the motor driver supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module mdsup_top_tb;
  import mdsup_pkg::*;
  // Shortened counts
  localparam int unsigned STEP = 20;
  localparam int unsigned EARLY = 3;
  localparam int unsigned OPEN = 10;
  localparam int unsigned POR = 5;
  localparam int unsigned PULSE = 4;
  // Stimulus, all valued at time zero
  logic clk = 1'b0, srst = 1'b1, clk_en = 1'b1, motor_enable = 1'b1;
  logic load_angle_transparent = 1'b1, load_angle_gain = LA_GAIN_DIV2;
  logic sleep_bit = 1'b0, pwm_period_start = 1'b0, zero_cross_end = 1'b0;
  logic temp_warn_in = 1'b0, temp_shut_in = 1'b0, cp_low_in = 1'b1;
  logic full_duty_x = 1'b0, full_duty_y = 1'b0, hard_clear_in = 1'b0;
  logic current_unreachable = 1'b0;
  logic [CUR_W-1:0] peak_amplitude_setting = 5'h00;
  logic [WDT_W-1:0] watchdog_interval_sel = 4'h0;
  logic [LA_W-1:0] coil_voltage = 10'h000;
  logic [OVC_W-1:0] ovc_x_in = 4'h0, ovc_y_in = 4'h0;
  // Host model commands
  logic wd_arm = 1'b0, rd_go = 1'b0, hold_cs = 1'b0;
  logic [9:0] svc_gap = 10'h000;
  // Host model outputs
  logic watchdog_enable_bit, watchdog_enable_wr, status_read, spi_cs_n;
  // Design outputs
  logic [CUR_W-1:0] coil_amplitude;
  logic [LA_W-1:0] load_angle_output;
  logic [OVC_W-1:0] overcurrent_x_flags, overcurrent_y_flags;
  logic drivers_on_x, drivers_on_y, thermal_warning_flag;
  logic thermal_shutdown_flag, open_coil_x_flag, open_coil_y_flag;
  logic charge_pump_fault_flag, boot_kind_flag, error_out_n;
  logic reset_out_o, reset_out_oe, core_clk_run;
  // Latched flags in one vector, one bit per source
  wire [9:0] flag_vec = {charge_pump_fault_flag, overcurrent_y_flags,
    overcurrent_x_flags, thermal_warning_flag};
  // Counters
  int n_fail, n_tests, cyc;
  mdsup_top #(.STEP_CYCLES(STEP), .EARLY_CYCLES(EARLY), .OPEN_CYCLES(OPEN),
    .POR_CYCLES(POR), .PULSE_CYCLES(PULSE)) mdsup_top_inst (.clk, .srst,
    .clk_en, .peak_amplitude_setting, .load_angle_transparent,
    .load_angle_gain, .watchdog_enable_bit, .watchdog_enable_wr,
    .watchdog_interval_sel, .sleep_bit, .motor_enable, .status_read,
    .spi_cs_n, .pwm_period_start, .coil_voltage, .zero_cross_end,
    .temp_warn_in, .temp_shut_in, .ovc_x_in, .ovc_y_in, .full_duty_x,
    .full_duty_y, .cp_low_in, .current_unreachable, .hard_clear_in,
    .coil_amplitude, .load_angle_output, .drivers_on_x, .drivers_on_y,
    .thermal_warning_flag, .thermal_shutdown_flag, .overcurrent_x_flags,
    .overcurrent_y_flags, .open_coil_x_flag, .open_coil_y_flag,
    .charge_pump_fault_flag, .boot_kind_flag, .error_out_n, .reset_out_o,
    .reset_out_oe, .core_clk_run);
  mdsup_host_model mdsup_host_model_inst (.clk, .srst, .wd_arm, .rd_go,
    .hold_cs, .svc_gap, .watchdog_enable_bit, .watchdog_enable_wr,
    .spi_cs_n, .status_read);
  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Status read through the host model
  task automatic status_rd();
    rd_go <= 1'b1;
    tick(1);
    rd_go <= 1'b0;
    tick(6);
  endtask : status_rd
  // Reset, then one status read; the pump flag left by reset follows cp_low_in
  task automatic do_reset();
    srst <= 1'b1;
    tick(20);
    srst <= 1'b0;
    tick(POR + 3);
    status_rd();
  endtask : do_reset
  // Write the watchdog enable bit once
  task automatic arm();
    wd_arm <= 1'b1;
    tick(1);
    wd_arm <= 1'b0;
  endtask : arm
  // Reset pin must stay released for n cycles
  task automatic wd_quiet(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n)
    begin
      tick(1);
      hit = hit | reset_out_oe;
    end
    `CHK(hit, 1'b0)
  endtask : wd_quiet
  // Watchdog reset must rise between lo and hi cycles, then pulse
  task automatic wd_fire(input int lo, input int hi);
    int n;
    n = 0;
    while (reset_out_oe !== 1'b1 && n < hi)
    begin
      tick(1);
      n++;
    end
    `CHK(n >= lo && reset_out_oe === 1'b1, 1'b1)
    n = 0;
    while (reset_out_oe === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    `CHK(n, PULSE)
    `CHK(boot_kind_flag, 1'b1)
  endtask : wd_fire
  // Drive one fault source by index
  task automatic set_fault(input int i, input logic v);
    if (i == 0)
      temp_warn_in <= v;
    else if (i < 5)
      ovc_x_in[i-1] <= v;
    else if (i < 9)
      ovc_y_in[i-5] <= v;
    else
      cp_low_in <= v;
  endtask : set_fault
  // Power up: reset pin held, pump flag and error active
  task automatic t_por();
    tick(20);
    srst <= 1'b0;
    tick(1);
    `CHK(reset_out_oe, 1'b1)
    `CHK(reset_out_o, 1'b0)
    `CHK({charge_pump_fault_flag, error_out_n}, 2'b10)
    `CHK(boot_kind_flag, 1'b0)
    tick(POR + 2);
    `CHK(reset_out_oe, 1'b0)
  endtask : t_por
  // Amplitude waits for a period start; load angle modes and gain
  task automatic t_amp_la();
    peak_amplitude_setting <= 5'h1A;
    tick(3);
    `CHK(coil_amplitude, CUR_RST)
    pwm_period_start <= 1'b1;
    tick(1);
    pwm_period_start <= 1'b0;
    tick(1);
    `CHK(coil_amplitude, 5'h1A)
    coil_voltage <= 10'h3FC;
    tick(2);
    `CHK(load_angle_output, 10'h1FE)
    load_angle_gain <= LA_GAIN_DIV4;
    tick(2);
    `CHK(load_angle_output, 10'h0FF)
    load_angle_transparent <= 1'b0;
    coil_voltage <= 10'h200;
    tick(3);
    `CHK(load_angle_output, 10'h0FF)
    zero_cross_end <= 1'b1;
    tick(1);
    zero_cross_end <= 1'b0;
    tick(2);
    `CHK(load_angle_output, 10'h080)
  endtask : t_amp_la
  // Each flag drives error; all but the pump flag latch and clear on read
  task automatic t_faults();
    int i;
    cp_low_in <= 1'b0;
    status_rd();
    `CHK({charge_pump_fault_flag, error_out_n}, 2'b01)
    hold_cs <= 1'b1;
    tick(2);
    temp_warn_in <= 1'b1;
    tick(3);
    `CHK(thermal_warning_flag, 1'b0)
    hold_cs <= 1'b0;
    tick(3);
    `CHK(thermal_warning_flag, 1'b1)
    temp_warn_in <= 1'b0;
    status_rd();
    for (i = 0; i < 10; i++)
    begin
      set_fault(i, 1'b1);
      tick(2);
      `CHK(error_out_n, 1'b0)
      set_fault(i, 1'b0);
      tick(2);
      `CHK(flag_vec, (i == 9) ? 10'h000 : 10'h001 << i)
      if (i > 0 && i < 9)
        `CHK({drivers_on_x, drivers_on_y}, 2'b00)
      status_rd();
      `CHK({flag_vec, error_out_n, drivers_on_x}, 12'h003)
    end
  endtask : t_faults
  // Shutdown and open coil
  task automatic t_open_tsd();
    temp_shut_in <= 1'b1;
    temp_warn_in <= 1'b1;
    tick(2);
    `CHK({thermal_shutdown_flag, drivers_on_x, drivers_on_y}, 3'b100)
    temp_shut_in <= 1'b0;
    status_rd();
    `CHK(thermal_shutdown_flag, 1'b1)
    temp_warn_in <= 1'b0;
    status_rd();
    `CHK({thermal_shutdown_flag, error_out_n}, 2'b01)
    full_duty_x <= 1'b1;
    tick(OPEN - 3);
    `CHK(open_coil_x_flag, 1'b0)
    tick(6);
    `CHK({open_coil_x_flag, drivers_on_x, error_out_n}, 3'b100)
    full_duty_x <= 1'b0;
    status_rd();
    full_duty_y <= 1'b1;
    current_unreachable <= 1'b1;
    tick(OPEN + 3);
    `CHK({open_coil_y_flag, drivers_on_y, error_out_n}, 3'b110)
    full_duty_y <= 1'b0;
    current_unreachable <= 1'b0;
    status_rd();
  endtask : t_open_tsd
  // Hard clear empties flags and disarms the watchdog quietly
  task automatic t_hard_clear();
    temp_warn_in <= 1'b1;
    tick(2);
    temp_warn_in <= 1'b0;
    arm();
    tick(5);
    hard_clear_in <= 1'b1;
    wd_quiet(CLR_MIN_CYC + 2);
    hard_clear_in <= 1'b0;
    tick(2);
    `CHK({thermal_warning_flag, coil_amplitude}, {1'b0, CUR_RST})
    wd_quiet(3 * STEP);
  endtask : t_hard_clear
  // Timeout for interval codes 0 and 3, service, early rewrite
  task automatic t_watchdog();
    do_reset();
    arm();
    wd_fire(STEP - 3, STEP + 5);
    do_reset();
    watchdog_interval_sel <= 4'h3;
    arm();
    wd_fire(4 * STEP - 3, 4 * STEP + 5);
    do_reset();
    watchdog_interval_sel <= 4'h0;
    svc_gap <= 10'h00A;
    arm();
    wd_quiet(5 * STEP);
    svc_gap <= 10'h001;
    tick(2);
    svc_gap <= 10'h000;
    wd_fire(0, 8);
  endtask : t_watchdog
  // Sleep stops clocks and drivers and freezes the timer
  task automatic t_sleep();
    do_reset();
    arm();
    tick(8);
    sleep_bit <= 1'b1;
    tick(2);
    `CHK({core_clk_run, drivers_on_x, drivers_on_y}, 3'b000)
    wd_quiet(3 * STEP);
    sleep_bit <= 1'b0;
    wd_fire(4, STEP - 3);
  endtask : t_sleep
  // Main sequence
  initial
  begin
    t_por();
    t_amp_la();
    t_faults();
    t_open_tsd();
    t_hard_clear();
    t_watchdog();
    t_sleep();
    tally_and_finish();
  end
endmodule : mdsup_top_tb
